/* hw/pcs_pkg.sv */
// constants and carrier types for the program counter and call stack
// assumes a single core clock and an APB register port
package pcs_pkg;
  // widths of counter, low byte, latch, target operand and stack
  localparam int PC_W = 13;
  localparam int LOW_W = 8;
  localparam int LATCH_W = 5;
  localparam int TGT_W = 11;
  localparam int DEPTH = 8;
  localparam int PTR_W = 3;
  // field positions inside the counter and the latch
  localparam int PC_HI_LSB = 8;
  localparam int PC_PAGE_LSB = 11;
  localparam int LATCH_PAGE_LSB = 3;
  // register byte offsets
  localparam logic [11:0] OFF_LOW = 12'h000;
  localparam logic [11:0] OFF_LATCH = 12'h004;
  // reset values
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [LATCH_W-1:0] LATCH_RST = 5'h00;
  localparam logic [PTR_W-1:0] SP_RST = 3'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  // interrupt entry address, plain default
  localparam logic [PC_W-1:0] INT_VEC = 13'h0004;
  // request from the instruction decoder and interrupt logic
  typedef struct packed {
    logic step;
    logic call;
    logic jump;
    logic ret;
    logic int_vec;
    logic low_wr;
    logic low_add;
    logic [TGT_W-1:0] target;
    logic [LOW_W-1:0] value;
  } pcs_core_s;
  // decoded operation, one-hot
  typedef enum logic [7:0] {
    OP_NONE = 8'h01,
    OP_STEP = 8'h02,
    OP_LOAD = 8'h04,
    OP_ADD = 8'h08,
    OP_JUMP = 8'h10,
    OP_CALL = 8'h20,
    OP_RET = 8'h40,
    OP_INT = 8'h80
  } pcs_op_e;
endpackage : pcs_pkg

/* hw/pcs_top.sv */
// program counter, high-part latch and eight-entry return stack
// assumes the core decoder drives CORE_I on CLK_I, one op per cycle
//
// Overview of operation
// - program counter is thirteen bits wide
// - low byte register readable and writable
// - upper counter bits hidden, loaded from latch
// - any reset clears the whole counter
// - low byte write copies latch into upper
// - call or jump takes page from latch
// - adding to low byte redirects execution
// - eight entries of thirteen bits stack
// - stack and pointer invisible to software
// - call or interrupt pushes return address
// - return instructions pop into the counter
// - push and pop leave latch unchanged
// - stack wraps circularly after eight pushes
// - no overflow or underflow status given
module pcs_top
  import pcs_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire pcs_core_s CORE_I,
  output logic [PC_W-1:0] PC_O
);

  // architectural state
  logic [PC_W-1:0] pc; // the counter itself
  logic [LATCH_W-1:0] latch; // high-part latch
  logic [PC_W-1:0] stack_mem [DEPTH]; // return addresses
  logic [PTR_W-1:0] sp; // next free slot

  // bus decode
  logic setup; // first cycle of a transfer
  logic access; // second cycle of a transfer
  logic hit_low; // address names the low byte
  logic hit_latch; // address names the latch
  logic sw_low_wr; // software write to the low byte
  logic sw_latch_wr; // software write to the latch

  // operation decode
  pcs_op_e op; // chosen operation this cycle
  logic push; // stack push this cycle
  logic pop; // stack pop this cycle
  logic [LOW_W-1:0] load_val; // byte for a low byte load
  logic [LOW_W-1:0] add_sum; // low byte plus operand
  logic [PTR_W-1:0] top_idx; // slot of the newest entry
  logic [PC_W-1:0] pop_val; // address a pop restores
  logic [PC_W-1:0] next_pc; // counter for next cycle

  // bus phases; zero wait states
  assign setup = PSEL_I & ~PENABLE_I;
  assign access = PSEL_I & PENABLE_I;
  assign PREADY_O = access;
  assign hit_low = (PADDR_I == OFF_LOW);
  assign hit_latch = (PADDR_I == OFF_LATCH);
  // a write takes effect only at the access edge
  assign sw_low_wr = access & PWRITE_I & hit_low;
  assign sw_latch_wr = access & PWRITE_I & hit_latch;

  // low byte source: core store or software store
  assign load_val = CORE_I.low_wr ? CORE_I.value : PWDATA_I[LOW_W-1:0];
  // computed branch sum wraps within the byte, latch gives the page
  assign add_sum = pc[LOW_W-1:0] + CORE_I.value;
  assign top_idx = sp - PTR_W'(1);
  assign pop_val = stack_mem[top_idx];

  // pick one operation; interrupt first, step last
  always_comb
  begin
    op = OP_NONE;
    if (CORE_I.int_vec)
    begin
      op = OP_INT;
    end
    else if (CORE_I.call)
    begin
      op = OP_CALL;
    end
    else if (CORE_I.jump)
    begin
      op = OP_JUMP;
    end
    else if (CORE_I.ret)
    begin
      op = OP_RET;
    end
    else if (CORE_I.low_add)
    begin
      op = OP_ADD;
    end
    else if (CORE_I.low_wr || sw_low_wr)
    begin
      // a bus store that meets a core op other than step is dropped; it wins over step
      op = OP_LOAD;
    end
    else if (CORE_I.step)
    begin
      op = OP_STEP;
    end
  end

  assign push = (op == OP_CALL) || (op == OP_INT);
  assign pop = (op == OP_RET);

  // next counter value per operation
  always_comb
  begin
    case (op)
      OP_STEP:
      begin
        next_pc = pc + PC_W'(1);
      end
      OP_LOAD:
      begin
        // upper five bits only ever come from the latch
        next_pc = {latch, load_val};
      end
      OP_ADD:
      begin
        next_pc = {latch, add_sum};
      end
      OP_JUMP, OP_CALL:
      begin
        // page bits from latch, rest from the operand
        next_pc = {latch[LATCH_W-1:LATCH_PAGE_LSB], CORE_I.target};
      end
      OP_RET:
      begin
        next_pc = pop_val;
      end
      OP_INT:
      begin
        next_pc = INT_VEC;
      end
      default:
      begin
        next_pc = pc;
      end
    endcase
  end

  // counter register; every reset lands here at zero
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      pc <= PC_RST;
    end
    else
    begin
      pc <= next_pc;
    end
  end

  assign PC_O = pc;

  // latch: only a software store changes it
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      latch <= LATCH_RST;
    end
    else if (sw_latch_wr)
    begin
      latch <= PWDATA_I[LATCH_W-1:0];
    end
  end

  // pointer wraps freely; nothing flags over- or underflow
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      sp <= SP_RST;
    end
    else if (push)
    begin
      sp <= sp + PTR_W'(1);
    end
    else if (pop)
    begin
      sp <= top_idx;
    end
  end

  // stack storage; ninth push overwrites the first slot
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        stack_mem[i] <= PC_RST;
      end
    end
    else if (push)
    begin
      // return address is the counter as it stands
      stack_mem[sp] <= pc;
    end
  end

  // read data and error caught in setup, shown in access
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      PRDATA_O <= RDATA_RST;
      PSLVERR_O <= 1'b0;
    end
    else if (setup)
    begin
      PSLVERR_O <= ~(hit_low | hit_latch);
      if (PWRITE_I)
      begin
        PRDATA_O <= RDATA_RST;
      end
      else if (hit_low)
      begin
        PRDATA_O <= {24'h00_0000, pc[LOW_W-1:0]};
      end
      else if (hit_latch)
      begin
        PRDATA_O <= {27'h000_0000, latch};
      end
      else
      begin
        // stack, pointer and upper bits have no address
        PRDATA_O <= RDATA_RST;
      end
    end
  end

  // checks, all on the core clock
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESETN_I);

  a_reset_clear: assert property ($rose(RESETN_I) |-> pc == PC_RST)
    else $error("counter not zero after reset");

  a_low_load: assert property ((op == OP_LOAD) |=> pc == {$past(latch), $past(load_val)})
    else $error("low byte store did not copy latch");

  a_page_bits: assert property ((op == OP_JUMP || op == OP_CALL)
      |=> pc[PC_W-1:PC_PAGE_LSB] == $past(latch[LATCH_W-1:LATCH_PAGE_LSB]))
    else $error("page bits not from latch");

  a_target_load: assert property ((op == OP_JUMP) |=> pc[TGT_W-1:0] == $past(CORE_I.target))
    else $error("target operand not loaded");

  // a call lands on its operand just like a jump
  a_call_target: assert property ((op == OP_CALL)
      |=> pc[TGT_W-1:0] == $past(CORE_I.target))
    else $error("call target operand not loaded");

  // interrupt entry always goes to the fixed vector
  a_int_vector: assert property ((op == OP_INT) |=> pc == INT_VEC)
    else $error("interrupt did not vector");

  a_add_branch: assert property ((op == OP_ADD) |=> pc[LOW_W-1:0] == $past(add_sum)
      && pc[PC_W-1:PC_HI_LSB] == $past(latch))
    else $error("computed branch wrong");

  a_call_push: assert property (push |=> sp == $past(sp) + PTR_W'(1)
      && stack_mem[$past(sp)] == $past(pc))
    else $error("push lost return address");

  a_ret_pop: assert property (pop |=> pc == $past(pop_val) && sp == $past(top_idx))
    else $error("pop did not restore counter");

  a_lifo_order: assert property ((op == OP_CALL) ##1 (op == OP_RET) |=> pc == $past(pc, 2))
    else $error("stack not last in first out");

  a_latch_hold: assert property ((push || pop) |=> latch == $past(latch))
    else $error("stack op changed latch");

  a_stack_wrap: assert property (push && sp == 3'h7 |=> sp == 3'h0)
    else $error("pointer did not wrap");

  a_bus_ready: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
    else $error("ready outside access");

  // main scenarios
  c_call_ret: cover property ((op == OP_CALL) ##[1:20] (op == OP_RET));
  c_wrap: cover property (push && sp == 3'h7);
  c_irq: cover property (op == OP_INT);
  c_sw_store: cover property (sw_low_wr && op == OP_LOAD);
  c_tight_ret: cover property ((op == OP_CALL) ##1 (op == OP_RET));

endmodule : pcs_top

/* test/pcs_core_model.sv */
// core decoder model: turns one chosen op into the request struct
// assumes the bench changes the op just after a rising edge
module pcs_core_model
  import pcs_pkg::*;
(
  input wire pcs_op_e op_i,
  input wire logic [TGT_W-1:0] tgt_i,
  input wire logic [LOW_W-1:0] val_i,
  output pcs_core_s core_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // one flag per op, so no priority case is ever exercised by accident
  always_comb
  begin
    core_o = '0;
    core_o.step = (op_i == OP_STEP);
    core_o.low_wr = (op_i == OP_LOAD);
    core_o.low_add = (op_i == OP_ADD);
    core_o.jump = (op_i == OP_JUMP);
    core_o.call = (op_i == OP_CALL);
    core_o.ret = (op_i == OP_RET);
    core_o.int_vec = (op_i == OP_INT);
    core_o.target = tgt_i;
    core_o.value = val_i;
  end
endmodule : pcs_core_model

/* test/program_counter_and_call_stack_bench.sv */
// bench for counter, latch and return stack over apb and core ops
// assumes zero-wait apb and one core op per cycle
module program_counter_and_call_stack_bench;
  import pcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  pcs_core_s core;
  pcs_op_e op;
  logic [TGT_W-1:0] tgt;
  logic [LOW_W-1:0] val;
  logic [PC_W-1:0] pc, pc_m, p9;
  // reference mirror; the 3-bit pointer wraps like the real stack
  logic [LATCH_W-1:0] latch_m;
  logic [PC_W-1:0] stk_m [DEPTH];
  logic [PTR_W-1:0] sp_m;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  pcs_top dut_u (.CLK_I(clk), .RESETN_I(resetn), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .CORE_I(core), .PC_O(pc));
  pcs_core_model core_u (.op_i(op), .tgt_i(tgt), .val_i(val), .core_o(core));
  // 250 MHz core clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard, far above the roughly 175 cycles the tests need
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      n_errors = n_errors + 1;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // wait for ready; only the hang guard ends a stuck transfer
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  // one core op, then the counter is compared with the mirror
  task automatic core_op(input pcs_op_e o, input logic [TGT_W-1:0] t,
    input logic [LOW_W-1:0] v);
    @(posedge clk);
    op <= o;
    tgt <= t;
    val <= v;
    @(posedge clk);
    op <= OP_NONE;
    #1;
    case (o)
      OP_STEP: pc_m = pc_m + 1'b1;
      OP_LOAD: pc_m = {latch_m, v};
      OP_ADD: pc_m = {latch_m, pc_m[7:0] + v};
      OP_JUMP: pc_m = {latch_m[4:3], t};
      OP_CALL, OP_INT:
      begin
        stk_m[sp_m] = pc_m;
        sp_m = sp_m + 1'b1;
        pc_m = (o == OP_INT) ? INT_VEC : {latch_m[4:3], t};
      end
      OP_RET:
      begin
        sp_m = sp_m - 1'b1;
        pc_m = stk_m[sp_m];
      end
      default: ;
    endcase
    chk(32'(pc), 32'(pc_m));
  endtask : core_op
  task automatic t_regs();
    chk(32'(pc), 32'h0000_0000);
    apb(1'b1, OFF_LATCH, 32'h0000_001F);
    latch_m = 5'h1F;
    chk(32'(pc), 32'h0000_0000);
    apb(1'b1, OFF_LOW, 32'h0000_005A);
    pc_m = 13'h1F5A;
    chk(32'(pc), 32'h0000_1F5A);
    apb(1'b0, OFF_LOW, 32'h0000_0000);
    chk(rd, 32'h0000_005A);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    $display("test regs done");
  endtask : t_regs
  task automatic t_branch();
    apb(1'b1, OFF_LATCH, 32'h0000_0015);
    latch_m = 5'h15;
    core_op(OP_JUMP, 11'h7FF, 8'h00);
    chk(32'(pc), 32'h0000_17FF);
    core_op(OP_STEP, 11'h000, 8'h00);
    chk(32'(pc), 32'h0000_1800);
    core_op(OP_ADD, 11'h000, 8'hF0);
    core_op(OP_ADD, 11'h000, 8'h20);
    chk(32'(pc), 32'h0000_1510);
    apb(1'b1, OFF_LATCH, 32'h0000_0016);
    latch_m = 5'h16;
    core_op(OP_LOAD, 11'h000, 8'h33);
    chk(32'(pc), 32'h0000_1633);
    $display("test branch done");
  endtask : t_branch
  task automatic t_stack();
    apb(1'b1, OFF_LATCH, 32'h0000_0008);
    latch_m = 5'h08;
    for (int i = 0; i < 9; i++)
    begin
      p9 = pc_m;
      core_op(OP_CALL, 11'(i * 37 + 5), 8'h00);
    end
    for (int i = 0; i < 9; i++)
      core_op(OP_RET, 11'h000, 8'h00);
    chk(32'(pc), 32'(p9));
    core_op(OP_INT, 11'h000, 8'h00);
    chk(32'(pc), 32'(INT_VEC));
    apb(1'b0, OFF_LATCH, 32'h0000_0000);
    chk(rd, 32'h0000_0008);
    chk({31'h0, err}, 32'h0000_0000);
    $display("test stack done");
  endtask : t_stack
  // call and return in adjacent cycles, then a bus store meeting a jump
  task automatic t_tight();
    @(posedge clk);
    op <= OP_CALL;
    tgt <= 11'h123;
    @(posedge clk);
    op <= OP_RET;
    @(posedge clk);
    op <= OP_NONE;
    #1;
    stk_m[sp_m] = pc_m;
    chk(32'(pc), 32'(pc_m));
    // the jump reaches the design at the access edge, so the store is dropped
    fork
      apb(1'b1, OFF_LOW, 32'h0000_0055);
      begin
        @(posedge clk);
        core_op(OP_JUMP, 11'h0AA, 8'h00);
      end
    join
    $display("test tight done");
  endtask : t_tight
  // main sequence, with a second reset in mid-run
  initial
  begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    op = OP_NONE;
    tgt = 11'h000;
    val = 8'h00;
    for (int r = 0; r < 2; r++)
    begin
      pc_m = PC_RST;
      latch_m = LATCH_RST;
      sp_m = SP_RST;
      foreach (stk_m[k])
        stk_m[k] = PC_RST;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      t_regs();
      t_branch();
      t_stack();
      t_tight();
      @(posedge clk);
      resetn <= 1'b0;
    end
    end_sim();
  end
endmodule : program_counter_and_call_stack_bench
